/* File: common/srh_pkg.sv */
// Shared constants and types for the sync restore and holdover control block.
// Assumes one 50 MHz clock and an 8-bit register port decoded from the serial link.
package srh_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Clock
  localparam int CLK_PERIOD_NS = 20;

  ////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] OFS_HSYNC_CTRL  = 8'h0e;
  localparam logic [7:0] OFS_SENSE_CTRL  = 8'h0f;
  localparam logic [7:0] OFS_SOG_THRESH  = 8'h10;
  localparam logic [7:0] OFS_RST_DELAY   = 8'h12;
  localparam logic [7:0] OFS_RST_LENGTH  = 8'h13;
  localparam logic [7:0] OFS_STATUS      = 8'h14;

  ////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int BIT_HSYNC_SENSE   = 6;
  localparam int BIT_RESTORE_EXT   = 7;
  localparam int BIT_RESTORE_SENSE = 6;
  localparam int BIT_HOLD_SENSE    = 3;

  ////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] RST_HSYNC_CTRL = 8'h40;
  localparam logic [7:0] RST_SENSE_CTRL = 8'h48;
  localparam logic [7:0] RST_RST_DELAY  = 8'h08;
  localparam logic [7:0] RST_RST_LENGTH = 8'h14;

  ////////////////////////////////////////////////////////////////////////
  // Threshold code: code times 10 mV above the negative peak
  localparam int         SOG_STEP_MV   = 10;
  localparam int         SOG_MIN_MV    = 10;
  localparam int         SOG_MAX_MV    = 330;
  localparam int         SOG_RST_MV    = 150;
  localparam logic [5:0] SOG_CODE_MIN  = 6'(SOG_MIN_MV / SOG_STEP_MV);
  localparam logic [5:0] SOG_CODE_MAX  = 6'(SOG_MAX_MV / SOG_STEP_MV);
  localparam logic [5:0] SOG_CODE_RST  = 6'(SOG_RST_MV / SOG_STEP_MV);

  ////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DELAY = 2'b01,
    ST_CLAMP = 2'b10
  } srh_state_t;

  typedef struct packed {
    logic       restore_ext;
    logic       restore_sense;
    logic [1:0] rsvd_hi;
    logic       hold_sense;
    logic [2:0] rsvd_lo;
  } srh_sense_t;

endpackage

/* File: hdl/srh_ctrl.sv */
// Restore window selection, PLL holdover and embedded sync slicer control.
// Assumes all inputs synchronous to MCLK_I and a decoded 8-bit register port.
//
// Operation
// - External restore input, when active, defines the ground clamp interval.
// - External restore honoured only when select bit 7 of 0FH is 1; resets 0.
// - Otherwise ignore it; time delay then duration from hsync trailing edge.
// - Restore sense bit 6 of 0FH sets the external input's active level.
// - Active holdover stops hsync tracking; clock keeps its frequency and phase.
// - Holdover sense bit 3 of 0FH sets the holdover input's active level.
// - Holdover sense bit is 1 after power-up.
// - Embedded sync threshold steps 10 mV, from 10 mV to 330 mV.
// - Embedded sync threshold resets to 150 mV.
// - Sliced embedded sync appears noninverted on the embedded sync output.
// - Only hsync leading edge used for the PLL reference; bit 6 of 0EH picks falling or rising.
`timescale 1ns/10ps

module srh_ctrl
  import srh_pkg::*;
(
  input  wire logic       MCLK_I,
  input  wire logic       RSTN_I,
  input  wire logic       HSYNC_I,
  input  wire logic       EXT_RESTORE_I,
  input  wire logic       HOLDOVER_I,
  input  wire logic       EMBEDDED_SYNC_INPUT_I,
  input  wire logic       REG_WR_I,
  input  wire logic [7:0] REG_ADDR_I,
  input  wire logic [7:0] REG_WDATA_I,
  output logic      [7:0] REG_RDATA_O,
  output logic            RESTORE_O,
  output logic            HOLDOVER_O,
  output logic            HS_REF_O,
  output logic            EMBEDDED_SYNC_OUTPUT_O,
  output logic      [5:0] SOG_THRESH_O
);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] hsync_ctrl_ff;
  srh_sense_t sense_ff;
  logic [5:0] sog_code_ff;
  logic [7:0] rst_delay_ff;
  logic [7:0] rst_length_ff;
  logic       hs_d_ff;
  srh_state_t state_ff;
  logic [7:0] cnt_ff;
  logic       restore_ff;
  logic       hold_ff;
  logic       hs_ref_ff;
  logic       sog_ff;
  logic [7:0] rdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // Decode
  logic       wr_hsync;
  logic       wr_sense;
  logic       wr_sog;
  logic       wr_delay;
  logic       wr_length;
  logic [5:0] sog_wcode;
  logic [5:0] nxt_sog_code;
  logic [7:0] status;
  logic [7:0] nxt_rdata;

  assign wr_hsync  = REG_WR_I && (REG_ADDR_I == OFS_HSYNC_CTRL);
  assign wr_sense  = REG_WR_I && (REG_ADDR_I == OFS_SENSE_CTRL);
  assign wr_sog    = REG_WR_I && (REG_ADDR_I == OFS_SOG_THRESH);
  assign wr_delay  = REG_WR_I && (REG_ADDR_I == OFS_RST_DELAY);
  assign wr_length = REG_WR_I && (REG_ADDR_I == OFS_RST_LENGTH);

  // Out-of-range codes saturate so the comparator never sees an illegal step
  assign sog_wcode    = REG_WDATA_I[5:0];
  assign nxt_sog_code = (sog_wcode < SOG_CODE_MIN) ? SOG_CODE_MIN :
                        (sog_wcode > SOG_CODE_MAX) ? SOG_CODE_MAX :
                        sog_wcode;

  assign status = {5'h00, (state_ff != ST_IDLE), hold_ff, restore_ff};

  always_comb begin
    if (REG_ADDR_I == OFS_HSYNC_CTRL) begin
      nxt_rdata = hsync_ctrl_ff & RST_HSYNC_CTRL;
    end else if (REG_ADDR_I == OFS_SENSE_CTRL) begin
      nxt_rdata = {sense_ff.restore_ext, sense_ff.restore_sense, 2'b00,
                   sense_ff.hold_sense, 3'b000};
    end else if (REG_ADDR_I == OFS_SOG_THRESH) begin
      nxt_rdata = {2'b00, sog_code_ff};
    end else if (REG_ADDR_I == OFS_RST_DELAY) begin
      nxt_rdata = rst_delay_ff;
    end else if (REG_ADDR_I == OFS_RST_LENGTH) begin
      nxt_rdata = rst_length_ff;
    end else if (REG_ADDR_I == OFS_STATUS) begin
      nxt_rdata = status;
    end else begin
      nxt_rdata = 8'h00;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      hsync_ctrl_ff <= RST_HSYNC_CTRL;
      sense_ff      <= RST_SENSE_CTRL;
      sog_code_ff   <= SOG_CODE_RST;
      rst_delay_ff  <= RST_RST_DELAY;
      rst_length_ff <= RST_RST_LENGTH;
      rdata_ff      <= 8'h00;
    end else begin
      if (wr_hsync) begin
        hsync_ctrl_ff <= REG_WDATA_I & RST_HSYNC_CTRL;
      end
      if (wr_sense) begin
        sense_ff <= REG_WDATA_I & 8'hc8;
      end
      if (wr_sog) begin
        sog_code_ff <= nxt_sog_code;
      end
      if (wr_delay) begin
        rst_delay_ff <= REG_WDATA_I;
      end
      if (wr_length) begin
        rst_length_ff <= REG_WDATA_I;
      end
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Hsync edges and input senses
  logic hs_sense;
  logic hs_lead;
  logic hs_trail;
  logic ext_sel;
  logic ext_act;
  logic hold_act;

  assign hs_sense = hsync_ctrl_ff[BIT_HSYNC_SENSE];
  // Sense 1: rising leading edge; sense 0: falling leading edge
  assign hs_lead  = (HSYNC_I != hs_d_ff) && (HSYNC_I == hs_sense);
  assign hs_trail = (HSYNC_I != hs_d_ff) && (HSYNC_I != hs_sense);
  assign ext_sel  = sense_ff.restore_ext;
  assign ext_act  = (EXT_RESTORE_I == sense_ff.restore_sense);
  assign hold_act = (HOLDOVER_I == sense_ff.hold_sense);

  ////////////////////////////////////////////////////////////////////////
  // Internal restore timer
  srh_state_t nxt_state;
  logic [7:0] nxt_cnt;
  logic       nxt_restore;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      ST_IDLE: begin
        if (hs_trail && !ext_sel) begin
          nxt_state = ST_DELAY;
          nxt_cnt   = rst_delay_ff;
        end
      end
      ST_DELAY: begin
        if (cnt_ff == 8'h00) begin
          nxt_state = ST_CLAMP;
          nxt_cnt   = rst_length_ff;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      ST_CLAMP: begin
        if (cnt_ff == 8'h00) begin
          nxt_state = ST_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_cnt   = 8'h00;
      end
    endcase
    // Selecting the external source abandons any window in progress
    if (ext_sel) begin
      nxt_state = ST_IDLE;
      nxt_cnt   = 8'h00;
    end
  end

  // External input is a don't-care unless selected
  assign nxt_restore = ext_sel ? ext_act : (nxt_state == ST_CLAMP);

  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      hs_d_ff    <= 1'b0;
      state_ff   <= ST_IDLE;
      cnt_ff     <= 8'h00;
      restore_ff <= 1'b0;
    end else begin
      hs_d_ff    <= HSYNC_I;
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      restore_ff <= nxt_restore;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Holdover and slicer outputs
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      hold_ff   <= 1'b0;
      hs_ref_ff <= 1'b0;
      sog_ff    <= 1'b0;
    end else begin
      hold_ff   <= hold_act;
      // PLL keeps its last frequency and phase with no reference edges
      hs_ref_ff <= hs_lead && !hold_act;
      sog_ff    <= EMBEDDED_SYNC_INPUT_I;
    end
  end

  assign REG_RDATA_O            = rdata_ff;
  assign RESTORE_O              = restore_ff;
  assign HOLDOVER_O             = hold_ff;
  assign HS_REF_O               = hs_ref_ff;
  assign EMBEDDED_SYNC_OUTPUT_O = sog_ff;
  assign SOG_THRESH_O           = sog_code_ff;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RSTN_I);

  chk_ext_restore_follow: assert property (
    ext_sel && ext_act && $past(ext_sel) |=> RESTORE_O)
    else $error("restore not asserted by external window");

  chk_ext_restore_sense: assert property (
    ext_sel && (EXT_RESTORE_I != sense_ff.restore_sense) |=> !RESTORE_O)
    else $error("restore asserted at inactive external level");

  chk_int_ignores_ext: assert property (
    !ext_sel && state_ff == ST_IDLE && !hs_trail |=> !RESTORE_O)
    else $error("restore without internal window");

  chk_int_delay_start: assert property (
    !ext_sel && state_ff == ST_IDLE && hs_trail && rst_delay_ff != 8'h00
    ##1 !ext_sel |-> state_ff == ST_DELAY && !RESTORE_O)
    else $error("internal delay did not start on trailing edge");

  chk_int_clamp_len: assert property (
    !ext_sel && state_ff == ST_DELAY && cnt_ff == 8'h00 && rst_length_ff == 8'h02
    ##1 !ext_sel [*3] |-> RESTORE_O && $past(RESTORE_O) && $past(RESTORE_O, 2))
    else $error("internal window length wrong");

  chk_hold_sense: assert property (
    HOLDOVER_I == sense_ff.hold_sense |=> HOLDOVER_O)
    else $error("holdover not asserted at active level");

  chk_hold_no_ref: assert property (
    HOLDOVER_O |-> !HS_REF_O)
    else $error("reference edge passed during holdover");

  chk_lead_edge: assert property (
    HS_REF_O |-> $past(HSYNC_I) == $past(hs_sense)
                 && $past(hs_d_ff) != $past(hs_sense))
    else $error("reference edge not on leading edge");

  chk_sog_range: assert property (
    SOG_THRESH_O >= SOG_CODE_MIN && SOG_THRESH_O <= SOG_CODE_MAX)
    else $error("threshold code out of range");

  chk_reset_values: assert property (
    !$past(RSTN_I) |-> sense_ff.hold_sense && !sense_ff.restore_ext
                       && SOG_THRESH_O == SOG_CODE_RST)
    else $error("wrong values after reset");

  chk_sog_pass: assert property (
    $rose(EMBEDDED_SYNC_INPUT_I) ##1 EMBEDDED_SYNC_INPUT_I |-> EMBEDDED_SYNC_OUTPUT_O)
    else $error("embedded sync output inverted or lost");

  cov_int_window:  cover property (state_ff == ST_DELAY ##[1:300] state_ff == ST_CLAMP);
  cov_ext_window:  cover property (ext_sel && $rose(RESTORE_O));
  cov_holdover:    cover property ($rose(HOLDOVER_O));
  cov_sog_clamped: cover property (wr_sog && sog_wcode > SOG_CODE_MAX);

endmodule

/* File: tb/srh_src_model.sv */
// Graphics source model: drives hsync pulses, clamp window and holdover strobes.
// Assumes the bench requests pulses one clock wide and synchronous to clk_i.
`timescale 1ns/10ps
module srh_src_model (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic hs_go_i,
  input  wire logic ext_use_i,
  input  wire logic ext_lvl_i,
  input  wire logic hold_use_i,
  input  wire logic hold_lvl_i,
  input  wire logic hold_sense_i,
  output logic      hsync_o,
  output logic      ext_o,
  output logic      hold_o
);
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;

  ////////////////////////////////////////////////////////////////////////
  // Active-high hsync pulse, four cycles wide
  assign nxt_cnt = hs_go_i ? 3'h4 : (cnt_ff != 3'h0) ? cnt_ff - 3'h1 : 3'h0;
  always_ff @(posedge clk_i) begin
    cnt_ff <= rst_n_i ? nxt_cnt : 3'h0;
  end
  assign hsync_o = (cnt_ff != 3'h0);

  ////////////////////////////////////////////////////////////////////////
  // Unused strobes are tied to their inactive level
  assign ext_o  = ext_use_i ? ext_lvl_i : 1'b0;
  assign hold_o = hold_use_i ? hold_lvl_i : ~hold_sense_i;
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for restore window, holdover and embedded sync control.
// Assumes the source model supplies the strobes; registers via the parallel port.
`timescale 1ns/10ps
module testbench
  import srh_pkg::*;
;
  logic        clk, rstn, go, ext_use, ext_lvl, hold_use, hold_lvl, hold_sense;
  logic        hsync, ext_r, hold_r, es_in, wr, restore, holdover, hs_ref, es_out;
  logic [7:0]  addr, wdata, rdata, rd, v;
  logic [5:0]  thresh;
  logic [31:0] seed = 32'hca1137ec;
  int          err_count, comparisons, e, l, r, f;
  srh_sense_t  sc;
  logic [7:0]  ra [7] = '{8'h0e, 8'h0f, 8'h10, 8'h12, 8'h13, 8'h14, 8'h55};
  logic [7:0]  rx [7] = '{8'h40, 8'h48, 8'h0f, 8'h08, 8'h14, 8'h00, 8'h00};
  logic [7:0]  cv [5] = '{8'h00, 8'h01, 8'h21, 8'h22, 8'h3f};
  logic [15:0] dl [3] = '{16'h0814, 16'h0002, 16'h0304};

  srh_ctrl srh_ctrl_i (.MCLK_I(clk), .RSTN_I(rstn), .HSYNC_I(hsync),
    .EXT_RESTORE_I(ext_r), .HOLDOVER_I(hold_r), .EMBEDDED_SYNC_INPUT_I(es_in),
    .REG_WR_I(wr), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
    .RESTORE_O(restore), .HOLDOVER_O(holdover), .HS_REF_O(hs_ref),
    .EMBEDDED_SYNC_OUTPUT_O(es_out), .SOG_THRESH_O(thresh));
  srh_src_model srh_src_model_i (.clk_i(clk), .rst_n_i(rstn), .hs_go_i(go),
    .ext_use_i(ext_use), .ext_lvl_i(ext_lvl), .hold_use_i(hold_use),
    .hold_lvl_i(hold_lvl), .hold_sense_i(hold_sense), .hsync_o(hsync),
    .ext_o(ext_r), .hold_o(hold_r));

  initial begin
    clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] clamp_code(input logic [7:0] c);
    return (c < 8'(SOG_CODE_MIN)) ? 8'(SOG_CODE_MIN) :
           (c > 8'(SOG_CODE_MAX)) ? 8'(SOG_CODE_MAX) : c;
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic rnd();
    seed = lfsr(seed);
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    wr = 1'b1;
    addr = a;
    wdata = d;
    step();
    wr = 1'b0;
    // Idle cycle so back-to-back writes never retoggle the strobe at once
    step();
  endtask
  task automatic rd_reg(input logic [7:0] a);
    addr = a;
    step();
    rd = rdata;
  endtask
  // Long tail lets any internal clamp window finish before the next test
  task automatic hs_pulse();
    e = 0;
    l = 0;
    r = 0;
    f = 0;
    go = 1'b1;
    step();
    go = 1'b0;
    for (int k = 2; k <= 48; k++) begin
      step();
      e += (hs_ref === 1'b1 && k <= 4) ? 1 : 0;
      l += (hs_ref === 1'b1 && k > 4) ? 1 : 0;
      f += (restore === 1'b1 && r == 0) ? k : 0;
      r += (restore === 1'b1) ? 1 : 0;
    end
  endtask
  task automatic done(input string n);
    $display("done: %s", n);
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, go, ext_use, ext_lvl, hold_use, hold_lvl, es_in, wr} = '0;
    hold_sense = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (3) step();
    rstn = 1'b1;
    check(8'(thresh), 8'h0f);
    foreach (ra[i]) begin
      rd_reg(ra[i]);
      check(rd, rx[i]);
    end
    done("reset");
    for (int i = 0; i < 10; i++) begin
      rnd();
      v = (i < 5) ? cv[i] : {2'b00, seed[5:0]};
      wr_reg(OFS_SOG_THRESH, v);
      rd_reg(OFS_SOG_THRESH);
      check(rd, clamp_code(v));
      check(8'(thresh), clamp_code(v));
    end
    done("threshold");
    for (int i = 0; i < 20; i++) begin
      rnd();
      es_in = seed[0];
      step();
      check(8'(es_out), 8'(seed[0]));
    end
    done("embedded sync");
    ext_use = 1'b1;
    for (int s = 0; s < 2; s++) begin
      sc = '{restore_ext: 1'b1, restore_sense: s[0], hold_sense: 1'b1, default: '0};
      wr_reg(OFS_SENSE_CTRL, sc);
      for (int i = 0; i < 12; i++) begin
        rnd();
        ext_lvl = seed[0];
        step();
        check(8'(restore), 8'(seed[0] == s[0]));
      end
    end
    wr_reg(OFS_SENSE_CTRL, RST_SENSE_CTRL);
    ext_lvl = 1'b1;
    foreach (dl[i]) begin
      wr_reg(OFS_RST_DELAY, dl[i][15:8]);
      wr_reg(OFS_RST_LENGTH, dl[i][7:0]);
      hs_pulse();
      check(8'(r), dl[i][7:0] + 8'h01);
      // Trailing edge is seen at step 6; window opens delay plus one later
      check(8'(f), dl[i][15:8] + 8'h07);
    end
    ext_use = 1'b0;
    done("restore");
    hold_use = 1'b1;
    for (int h = 0; h < 2; h++) begin
      sc = '{restore_sense: 1'b1, hold_sense: h[0], default: '0};
      hold_sense = h[0];
      wr_reg(OFS_SENSE_CTRL, sc);
      for (int i = 0; i < 12; i++) begin
        rnd();
        hold_lvl = seed[0];
        step();
        check(8'(holdover), 8'(seed[0] == h[0]));
      end
    end
    hold_lvl = 1'b1;
    hs_pulse();
    check(8'(e + l), 8'h00);
    hold_use = 1'b0;
    hs_pulse();
    check(8'(e * 16 + l), 8'h10);
    wr_reg(OFS_HSYNC_CTRL, 8'h00);
    hs_pulse();
    check(8'(e * 16 + l), 8'h01);
    done("holdover and hsync");
    report_and_stop();
  end
endmodule
